/* File: lesr_dev_end.sv */
// lesr_dev_end: documented port end with its AXI4-Lite register file
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module lesr_dev_end
  import lesr_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic NRST_I,
  lesr_link_if.dev_end LNK,
  input wire logic LINK_UP_I,
  input wire logic IN_ERR_I,
  input wire logic OUT_ERR_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I
);

  typedef struct packed {
    logic up_m, up_s, rdy, port_ok, in_stop, out_stop, port_err;
    logic [1:0] det;
    logic [31:0] cs_tx;
    logic sw_pend, pend_lreq, pend_lresp, pend_pa;
    lesr_ack_t pa_ack, inb, outs, outb, lm_ack;
    logic lm_vld;
    logic [4:0] lm_stat;
    logic aw_ok, w_ok;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic tx_vld;
    lesr_sym_t tx_sym;
    logic pkt_vld;
    lesr_ack_t pkt_ack;
  } lesr_dev_st_t;

  lesr_dev_st_t s_r;
  lesr_dev_st_t s_nxt;
  logic wr;
  logic pkt_req;
  logic can_send;
  logic [31:0] wd;
  logic [31:0] ack_word;
  logic [31:0] ack_wd;

  assign can_send = s_r.port_ok && !s_r.out_stop && s_r.outb == s_r.outs;
  assign wd = strb_merge(32'h00000000, s_r.w_data, s_r.w_strb);
  assign ack_word = ({27'h0, s_r.inb} << AS_INB_LSB)
                  | ({27'h0, s_r.outs} << AS_OUTS_LSB)
                  | ({27'h0, s_r.outb} << AS_OUTB_LSB);
  // unstrobed bytes keep their current identifiers
  assign ack_wd = strb_merge(ack_word, s_r.w_data, s_r.w_strb);

  always_comb begin
    s_nxt = s_r;
    wr = s_r.aw_ok && s_r.w_ok && !s_r.bvalid;
    pkt_req = 1'b0;
    s_nxt.up_m = LINK_UP_I;
    s_nxt.up_s = s_r.up_m;
    s_nxt.rdy = s_r.up_s;
    s_nxt.port_ok = s_r.up_s && LNK.fn_rdy;
    s_nxt.tx_vld = 1'b0;
    s_nxt.pkt_vld = 1'b0;
    // ----------------------------------------------------------------
    // AXI4-Lite write: address and data latched independently
    // ----------------------------------------------------------------
    if (S_AXI_AWVALID_I && s_r.awready) begin
      s_nxt.aw_ok = 1'b1;
      s_nxt.aw_addr = S_AXI_AWADDR_I;
    end
    if (S_AXI_WVALID_I && s_r.wready) begin
      s_nxt.w_ok = 1'b1;
      s_nxt.w_data = S_AXI_WDATA_I;
      s_nxt.w_strb = S_AXI_WSTRB_I;
    end
    if (s_r.bvalid && S_AXI_BREADY_I) begin
      s_nxt.bvalid = 1'b0;
    end
    if (wr) begin
      s_nxt.aw_ok = 1'b0;
      s_nxt.w_ok = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      unique case (s_r.aw_addr)
        OFF_ERR_STAT: begin
          if (wd[ES_PORT_ERR]) begin
            s_nxt.port_err = 1'b0;
          end
        end
        OFF_ERR_DET: begin
          s_nxt.det = s_r.det & ~wd[1:0];
        end
        OFF_CS_TX: begin
          s_nxt.cs_tx = strb_merge(s_r.cs_tx, s_r.w_data, s_r.w_strb);
          s_nxt.sw_pend = 1'b1;
          s_nxt.lm_vld = 1'b0;
        end
        OFF_LM_RESP: begin
          s_nxt.bresp = RESP_OKAY;
        end
        OFF_ACK_STAT: begin
          s_nxt.inb = ack_wd[AS_INB_LSB +: ACK_W];
          s_nxt.outs = ack_wd[AS_OUTS_LSB +: ACK_W];
          s_nxt.outb = ack_wd[AS_OUTB_LSB +: ACK_W];
        end
        OFF_PKT_TX: begin
          pkt_req = 1'b1;
        end
        default: begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_nxt.awready = !s_nxt.aw_ok && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_ok && !s_nxt.bvalid;
    // ----------------------------------------------------------------
    // AXI4-Lite read
    // ----------------------------------------------------------------
    if (s_r.rvalid && S_AXI_RREADY_I) begin
      s_nxt.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID_I && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = RESP_OKAY;
      s_nxt.rdata = 32'h00000000;
      unique case (S_AXI_ARADDR_I)
        OFF_ERR_STAT: begin
          s_nxt.rdata[ES_PORT_OK] = s_r.port_ok;
          s_nxt.rdata[ES_IN_STOP] = s_r.in_stop;
          s_nxt.rdata[ES_OUT_STOP] = s_r.out_stop;
          s_nxt.rdata[ES_CAN_SEND] = can_send;
          s_nxt.rdata[ES_PORT_ERR] = s_r.port_err;
        end
        OFF_ERR_DET: s_nxt.rdata[1:0] = s_r.det;
        OFF_CS_TX: s_nxt.rdata = s_r.cs_tx;
        OFF_LM_RESP: begin
          s_nxt.rdata[LM_VALID] = s_r.lm_vld;
          s_nxt.rdata[LM_ACK_LSB +: ACK_W] = s_r.lm_ack;
          s_nxt.rdata[LM_STAT_LSB +: 5] = s_r.lm_stat;
        end
        OFF_ACK_STAT: s_nxt.rdata = ack_word;
        OFF_PKT_TX: s_nxt.rdata = 32'h00000000;
        default: s_nxt.rresp = RESP_SLVERR;
      endcase
    end
    s_nxt.arready = !s_nxt.rvalid;
    // ----------------------------------------------------------------
    // symbol transmit: software symbol first, then replies, then acks
    // ----------------------------------------------------------------
    if (s_r.sw_pend) begin
      s_nxt.tx_vld = 1'b1;
      s_nxt.tx_sym = cs_decode(s_r.cs_tx);
      s_nxt.sw_pend = 1'b0;
    end else if (s_r.pend_lreq || s_r.pend_lresp) begin
      // both replies share one symbol when both are owed
      s_nxt.tx_vld = 1'b1;
      s_nxt.tx_sym.st0 = s_r.pend_lresp ? ST0_LRESP : ST0_STAT;
      s_nxt.tx_sym.p0 = s_r.inb;
      s_nxt.tx_sym.p1 = port_status(s_r.port_ok, s_r.in_stop, s_r.out_stop);
      s_nxt.tx_sym.st1 = s_r.pend_lreq ? ST1_LREQ : ST1_NOP;
      s_nxt.tx_sym.cmd = CMD_INSTAT;
      s_nxt.pend_lreq = 1'b0;
      s_nxt.pend_lresp = 1'b0;
    end else if (s_r.pend_pa) begin
      s_nxt.tx_vld = 1'b1;
      s_nxt.tx_sym = '{st0: ST0_PA, p0: s_r.pa_ack, p1: 5'h00,
                       st1: ST1_NOP, cmd: 3'h0};
      s_nxt.pend_pa = 1'b0;
    end
    // ----------------------------------------------------------------
    // symbol receive; sets land after the clears so none is lost
    // ----------------------------------------------------------------
    if (LNK.fn_sym_vld) begin
      if (LNK.fn_sym.st0 == ST0_PNA) begin
        s_nxt.pend_lreq = 1'b1;
      end
      if (LNK.fn_sym.st0 == ST0_LRESP) begin
        // identifiers stay as they are; the response is kept and output stop is cleared
        s_nxt.out_stop = 1'b0;
        s_nxt.lm_vld = 1'b1;
        s_nxt.lm_ack = LNK.fn_sym.p0;
        s_nxt.lm_stat = LNK.fn_sym.p1;
      end
      if (LNK.fn_sym.st0 == ST0_PA && LNK.fn_sym.p0 == s_r.outs) begin
        s_nxt.outs = ack_inc(s_r.outs);
      end
      if (LNK.fn_sym.st1 == ST1_LREQ) begin
        s_nxt.in_stop = 1'b0;
        s_nxt.pend_lresp = 1'b1;
      end
    end
    // ----------------------------------------------------------------
    // packets and maintenance
    // ----------------------------------------------------------------
    if (LNK.fn_pkt_vld && s_r.port_ok && !s_r.in_stop) begin
      if (LNK.fn_pkt_ack == s_r.inb) begin
        s_nxt.inb = ack_inc(s_r.inb);
        s_nxt.pend_pa = 1'b1;
        s_nxt.pa_ack = LNK.fn_pkt_ack;
      end else begin
        // out-of-sequence identifier stops input until recovery
        s_nxt.in_stop = 1'b1;
        s_nxt.det[ED_IN] = 1'b1;
        s_nxt.port_err = 1'b1;
      end
    end
    if (pkt_req && can_send) begin
      s_nxt.pkt_vld = 1'b1;
      s_nxt.pkt_ack = s_r.outb;
      s_nxt.outb = ack_inc(s_r.outb);
    end
    if (LNK.fn_mnt_vld) begin
      s_nxt.inb = LNK.fn_mnt_inb;
      s_nxt.outs = LNK.fn_mnt_outs;
      s_nxt.outb = LNK.fn_mnt_outb;
    end
    if (IN_ERR_I) begin
      s_nxt.in_stop = 1'b1;
      s_nxt.det[ED_IN] = 1'b1;
      s_nxt.port_err = 1'b1;
    end
    if (OUT_ERR_I) begin
      s_nxt.out_stop = 1'b1;
      s_nxt.det[ED_OUT] = 1'b1;
      s_nxt.port_err = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign LNK.dn_rdy = s_r.rdy;
  assign LNK.dn_sym_vld = s_r.tx_vld;
  assign LNK.dn_sym = s_r.tx_sym;
  assign LNK.dn_pkt_vld = s_r.pkt_vld;
  assign LNK.dn_pkt_ack = s_r.pkt_ack;
  assign S_AXI_AWREADY_O = s_r.awready;
  assign S_AXI_WREADY_O = s_r.wready;
  assign S_AXI_BVALID_O = s_r.bvalid;
  assign S_AXI_BRESP_O = s_r.bresp;
  assign S_AXI_ARREADY_O = s_r.arready;
  assign S_AXI_RVALID_O = s_r.rvalid;
  assign S_AXI_RDATA_O = s_r.rdata;
  assign S_AXI_RRESP_O = s_r.rresp;

endmodule : lesr_dev_end

/* File: lesr_far_end.sv */
// lesr_far_end: the link partner port, driven from plain user strobes
`timescale 1ns/1ps
module lesr_far_end
  import lesr_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic NRST_I,
  lesr_link_if.far_end LNK,
  input wire logic LINK_UP_I,
  input wire logic IN_ERR_I,
  input wire logic OUT_ERR_I,
  input wire logic RECOVER_I,
  input wire logic PKT_SEND_I,
  input wire logic ALIGN_I,
  output logic PORT_OK_O,
  output logic IN_STOP_O,
  output logic OUT_STOP_O,
  output logic RESP_VLD_O,
  output lesr_ack_t RESP_ACK_O,
  output lesr_ack_t INB_O,
  output lesr_ack_t OUTS_O,
  output lesr_ack_t OUTB_O
);

  typedef struct packed {
    logic up_m, up_s, rdy, port_ok, in_stop, out_stop;
    logic pend_lreq, pend_lresp, pend_pa;
    lesr_ack_t pa_ack, inb, outs, outb, resp_ack;
    logic resp_vld;
    logic tx_vld;
    lesr_sym_t tx_sym;
    logic pkt_vld;
    lesr_ack_t pkt_ack;
    logic mnt_vld;
    lesr_ack_t mnt_inb, mnt_outs, mnt_outb;
  } lesr_far_st_t;

  lesr_far_st_t s_r;
  lesr_far_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.up_m = LINK_UP_I;
    s_nxt.up_s = s_r.up_m;
    s_nxt.rdy = s_r.up_s;
    s_nxt.port_ok = s_r.up_s && LNK.dn_rdy;
    s_nxt.tx_vld = 1'b0;
    s_nxt.pkt_vld = 1'b0;
    s_nxt.mnt_vld = 1'b0;
    // ----------------------------------------------------------------
    // symbol transmit: user recovery first, then replies, then acks
    // ----------------------------------------------------------------
    if (RECOVER_I) begin
      s_nxt.tx_vld = 1'b1;
      s_nxt.tx_sym = cs_decode(CS_RECOVERY);
      s_nxt.resp_vld = 1'b0;
    end else if (s_r.pend_lreq || s_r.pend_lresp) begin
      s_nxt.tx_vld = 1'b1;
      s_nxt.tx_sym.st0 = s_r.pend_lresp ? ST0_LRESP : ST0_STAT;
      s_nxt.tx_sym.p0 = s_r.inb;
      s_nxt.tx_sym.p1 = port_status(s_r.port_ok, s_r.in_stop, s_r.out_stop);
      s_nxt.tx_sym.st1 = s_r.pend_lreq ? ST1_LREQ : ST1_NOP;
      s_nxt.tx_sym.cmd = CMD_INSTAT;
      s_nxt.pend_lreq = 1'b0;
      s_nxt.pend_lresp = 1'b0;
    end else if (s_r.pend_pa) begin
      s_nxt.tx_vld = 1'b1;
      s_nxt.tx_sym = '{st0: ST0_PA, p0: s_r.pa_ack, p1: 5'h00,
                       st1: ST1_NOP, cmd: 3'h0};
      s_nxt.pend_pa = 1'b0;
    end
    // ----------------------------------------------------------------
    // symbol receive; sets land after the clears above
    // ----------------------------------------------------------------
    if (LNK.dn_sym_vld) begin
      if (LNK.dn_sym.st0 == ST0_PNA) begin
        s_nxt.pend_lreq = 1'b1;
      end
      if (LNK.dn_sym.st0 == ST0_LRESP) begin
        s_nxt.out_stop = 1'b0;
        s_nxt.resp_vld = 1'b1;
        s_nxt.resp_ack = LNK.dn_sym.p0;
      end
      if (LNK.dn_sym.st0 == ST0_PA && LNK.dn_sym.p0 == s_r.outs) begin
        s_nxt.outs = ack_inc(s_r.outs);
      end
      if (LNK.dn_sym.st1 == ST1_LREQ) begin
        s_nxt.in_stop = 1'b0;
        s_nxt.pend_lresp = 1'b1;
      end
    end
    // ----------------------------------------------------------------
    // packets
    // ----------------------------------------------------------------
    if (LNK.dn_pkt_vld && s_r.port_ok && !s_r.in_stop) begin
      if (LNK.dn_pkt_ack == s_r.inb) begin
        s_nxt.inb = ack_inc(s_r.inb);
        s_nxt.pend_pa = 1'b1;
        s_nxt.pa_ack = LNK.dn_pkt_ack;
      end else begin
        s_nxt.in_stop = 1'b1;
      end
    end
    if (PKT_SEND_I && s_r.port_ok && !s_r.out_stop && s_r.outb == s_r.outs)
    begin
      s_nxt.pkt_vld = 1'b1;
      s_nxt.pkt_ack = s_r.outb;
      s_nxt.outb = ack_inc(s_r.outb);
    end else if (ALIGN_I && s_r.resp_vld) begin
      s_nxt.outb = s_r.resp_ack;
      s_nxt.outs = s_r.resp_ack;
      s_nxt.mnt_vld = 1'b1;
      s_nxt.mnt_outs = s_r.inb;
      s_nxt.mnt_outb = s_r.inb;
      s_nxt.mnt_inb = ack_inc(s_r.resp_ack);
    end
    if (IN_ERR_I) begin
      s_nxt.in_stop = 1'b1;
    end
    if (OUT_ERR_I) begin
      s_nxt.out_stop = 1'b1;
    end
  end

  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign LNK.fn_rdy = s_r.rdy;
  assign LNK.fn_sym_vld = s_r.tx_vld;
  assign LNK.fn_sym = s_r.tx_sym;
  assign LNK.fn_pkt_vld = s_r.pkt_vld;
  assign LNK.fn_pkt_ack = s_r.pkt_ack;
  assign LNK.fn_mnt_vld = s_r.mnt_vld;
  assign LNK.fn_mnt_inb = s_r.mnt_inb;
  assign LNK.fn_mnt_outs = s_r.mnt_outs;
  assign LNK.fn_mnt_outb = s_r.mnt_outb;
  assign PORT_OK_O = s_r.port_ok;
  assign IN_STOP_O = s_r.in_stop;
  assign OUT_STOP_O = s_r.out_stop;
  assign RESP_VLD_O = s_r.resp_vld;
  assign RESP_ACK_O = s_r.resp_ack;
  assign INB_O = s_r.inb;
  assign OUTS_O = s_r.outs;
  assign OUTB_O = s_r.outb;

endmodule : lesr_far_end

/* File: lesr_link_if.sv */
// lesr_link_if: symbol, packet and maintenance wires between the two ends
`timescale 1ns/1ps
interface lesr_link_if;
  import lesr_pkg::*;

  // device end to far end
  logic dn_rdy;
  logic dn_sym_vld;
  lesr_sym_t dn_sym;
  logic dn_pkt_vld;
  lesr_ack_t dn_pkt_ack;
  // far end to device end
  logic fn_rdy;
  logic fn_sym_vld;
  lesr_sym_t fn_sym;
  logic fn_pkt_vld;
  lesr_ack_t fn_pkt_ack;
  logic fn_mnt_vld;
  lesr_ack_t fn_mnt_inb;
  lesr_ack_t fn_mnt_outs;
  lesr_ack_t fn_mnt_outb;

  modport dev_end (
    output dn_rdy, dn_sym_vld, dn_sym, dn_pkt_vld, dn_pkt_ack,
    input fn_rdy, fn_sym_vld, fn_sym, fn_pkt_vld, fn_pkt_ack,
    input fn_mnt_vld, fn_mnt_inb, fn_mnt_outs, fn_mnt_outb
  );
  modport far_end (
    input dn_rdy, dn_sym_vld, dn_sym, dn_pkt_vld, dn_pkt_ack,
    output fn_rdy, fn_sym_vld, fn_sym, fn_pkt_vld, fn_pkt_ack,
    output fn_mnt_vld, fn_mnt_inb, fn_mnt_outs, fn_mnt_outb
  );
endinterface : lesr_link_if

/* File: lesr_pkg.sv */
// lesr_pkg: shared constants, symbol types and helpers for the recovery link
package lesr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ACK_W = 5;
  localparam int ADDR_W = 8;
  typedef logic [ACK_W-1:0] lesr_ack_t;

  // ----------------------------------------------------------------
  // control symbol encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] ST0_PA = 3'h0;
  localparam logic [2:0] ST0_PNA = 3'h2;
  localparam logic [2:0] ST0_STAT = 3'h4;
  localparam logic [2:0] ST0_LRESP = 3'h6;
  localparam logic [2:0] ST1_LREQ = 3'h4;
  localparam logic [2:0] ST1_NOP = 3'h7;
  localparam logic [2:0] CMD_INSTAT = 3'h4;
  localparam logic [31:0] CS_RECOVERY = 32'h40fc8000;

  typedef struct packed {
    logic [2:0] st0;
    logic [4:0] p0;
    logic [4:0] p1;
    logic [2:0] st1;
    logic [2:0] cmd;
  } lesr_sym_t;

  // control symbol transmit word layout
  localparam int CS_ST0_LSB = 29;
  localparam int CS_P0_LSB = 24;
  localparam int CS_P1_LSB = 19;
  localparam int CS_ST1_LSB = 16;
  localparam int CS_CMD_LSB = 13;

  // ----------------------------------------------------------------
  // register map of the device end
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_ERR_STAT = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ERR_DET = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CS_TX = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_LM_RESP = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_ACK_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PKT_TX = 8'h14;

  localparam int ES_PORT_OK = 0;
  localparam int ES_IN_STOP = 1;
  localparam int ES_OUT_STOP = 2;
  localparam int ES_CAN_SEND = 3;
  localparam int ES_PORT_ERR = 4;
  localparam int ED_IN = 0;
  localparam int ED_OUT = 1;
  localparam int LM_VALID = 31;
  localparam int LM_ACK_LSB = 5;
  localparam int LM_STAT_LSB = 0;
  localparam int AS_INB_LSB = 24;
  localparam int AS_OUTS_LSB = 8;
  localparam int AS_OUTB_LSB = 0;
  localparam logic [31:0] CS_TX_RST = 32'h00000000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic lesr_sym_t cs_decode(input logic [31:0] w);
    lesr_sym_t s;
    s.st0 = w[CS_ST0_LSB +: 3];
    s.p0 = w[CS_P0_LSB +: 5];
    s.p1 = w[CS_P1_LSB +: 5];
    s.st1 = w[CS_ST1_LSB +: 3];
    s.cmd = w[CS_CMD_LSB +: 3];
    return s;
  endfunction : cs_decode

  // identifier arithmetic wraps at the field width
  function automatic lesr_ack_t ack_inc(input lesr_ack_t a);
    return lesr_ack_t'(a + 1'b1);
  endfunction : ack_inc

  function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction : strb_merge

  // local port status carried in a link-response
  function automatic logic [4:0] port_status(input logic ok,
                                             input logic in_stop,
                                             input logic out_stop);
    return {2'h0, out_stop, in_stop, ok};
  endfunction : port_status

endpackage : lesr_pkg

/* File: lesr_props.sv */
// lesr_props: link checks between the device end and the far end
`timescale 1ns/1ps
module lesr_props
  import lesr_pkg::*;
(
  input wire logic MCLK_I,
  input wire logic NRST_I,
  input wire logic dn_rdy,
  input wire logic dn_sym_vld,
  input wire lesr_sym_t dn_sym,
  input wire logic dn_pkt_vld,
  input wire logic fn_rdy,
  input wire logic fn_sym_vld,
  input wire lesr_sym_t fn_sym,
  input wire logic fn_pkt_vld,
  input wire logic fn_mnt_vld,
  input wire lesr_ack_t fn_mnt_inb,
  input wire lesr_ack_t fn_mnt_outs,
  input wire lesr_ack_t fn_mnt_outb
);
  // far end realigns from the last id the device reported
  lesr_ack_t resp_r;
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      resp_r <= '0;
    end else if (dn_sym_vld && dn_sym.st0 == ST0_LRESP) begin
      resp_r <= dn_sym.p0;
    end
  end
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!NRST_I);
  // ----
  // assertions
  // ----
  a_dn_pkt_gate: assert property (
    dn_pkt_vld |-> dn_rdy && fn_rdy)
    else $error("device packet with link down");
  a_fn_pkt_gate: assert property (
    fn_pkt_vld |-> dn_rdy && fn_rdy)
    else $error("far packet with link down");
  a_dev_pna_ans: assert property (
    fn_sym_vld && fn_sym.st0 == ST0_PNA && dn_rdy
      |-> ##[1:4] dn_sym_vld && dn_sym.st1 == ST1_LREQ)
    else $error("device ignored not-accepted");
  a_far_pna_ans: assert property (
    dn_sym_vld && dn_sym.st0 == ST0_PNA && fn_rdy
      |-> ##[1:4] fn_sym_vld && fn_sym.st1 == ST1_LREQ)
    else $error("far end ignored not-accepted");
  a_dev_lreq_ans: assert property (
    fn_sym_vld && fn_sym.st1 == ST1_LREQ && dn_rdy
      |-> ##[1:4] dn_sym_vld && dn_sym.st0 == ST0_LRESP)
    else $error("device ignored link request");
  a_far_lreq_ans: assert property (
    dn_sym_vld && dn_sym.st1 == ST1_LREQ && fn_rdy
      |-> ##[1:4] fn_sym_vld && fn_sym.st0 == ST0_LRESP)
    else $error("far end ignored link request");
  a_mnt_outs_eq: assert property (
    fn_mnt_vld |-> fn_mnt_outs == fn_mnt_outb)
    else $error("maintenance ids differ");
  a_mnt_inb_inc: assert property (
    fn_mnt_vld |-> fn_mnt_inb == lesr_ack_t'(resp_r + 5'h1))
    else $error("maintenance inbound wrong");
  c_dev_rec: cover property (dn_sym_vld && dn_sym.st0 == ST0_PNA);
  c_far_rec: cover property (fn_sym_vld && fn_sym.st0 == ST0_PNA);
  c_realign: cover property (fn_mnt_vld);
endmodule : lesr_props

/* File: lesr_tb_top.sv */
// lesr_tb_top: self-checking bench joining device and far ends
`timescale 1ns/1ps
module lesr_tb_top
  import lesr_pkg::*;
;
  logic clk, nrst, d_lup, f_lup, awv, awr, wv, wrdy, bv, brdy;
  logic arv, arr, rv, rrdy, f_ok, f_is, f_os, f_rv;
  logic [1:0] d_err, br, rr, bres, rres;
  logic [4:0] fs; // recover, packet, align, in err, out err
  logic [7:0] awa, ara;
  logic [31:0] wd, rdata, rd_v, lf;
  logic [3:0] wst;
  lesr_ack_t f_ra, f_inb, f_outs, f_outb, r1;
  int n_mismatch, cmp_count, n_dp, n_fp, k;
  lesr_sym_t dq[$];
  lesr_link_if lnk();
  lesr_dev_end lesr_dev_end_inst (.MCLK_I(clk), .NRST_I(nrst),
    .LNK(lnk.dev_end), .LINK_UP_I(d_lup), .IN_ERR_I(d_err[1]),
    .OUT_ERR_I(d_err[0]), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(wst),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy), .S_AXI_BRESP_O(br),
    .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(brdy), .S_AXI_ARADDR_I(ara),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rr), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rrdy));
  lesr_far_end lesr_far_end_inst (.MCLK_I(clk), .NRST_I(nrst),
    .LNK(lnk.far_end), .LINK_UP_I(f_lup), .IN_ERR_I(fs[1]),
    .OUT_ERR_I(fs[0]), .RECOVER_I(fs[4]), .PKT_SEND_I(fs[3]),
    .ALIGN_I(fs[2]), .PORT_OK_O(f_ok), .IN_STOP_O(f_is),
    .OUT_STOP_O(f_os), .RESP_VLD_O(f_rv), .RESP_ACK_O(f_ra),
    .INB_O(f_inb), .OUTS_O(f_outs), .OUTB_O(f_outb));
  lesr_props lesr_props_inst (.MCLK_I(clk), .NRST_I(nrst),
    .dn_rdy(lnk.dn_rdy), .dn_sym_vld(lnk.dn_sym_vld), .dn_sym(lnk.dn_sym),
    .dn_pkt_vld(lnk.dn_pkt_vld), .fn_rdy(lnk.fn_rdy),
    .fn_sym_vld(lnk.fn_sym_vld), .fn_sym(lnk.fn_sym),
    .fn_pkt_vld(lnk.fn_pkt_vld), .fn_mnt_vld(lnk.fn_mnt_vld),
    .fn_mnt_inb(lnk.fn_mnt_inb), .fn_mnt_outs(lnk.fn_mnt_outs),
    .fn_mnt_outb(lnk.fn_mnt_outb));
  // ----
  // helpers
  // ----
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] ackw(input lesr_ack_t i, input lesr_ack_t o);
    return {3'h0, i, 11'h0, o, 3'h0, o};
  endfunction : ackw
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end while (!bv);
    bres = br;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    rd_v = rdata;
    rres = rr;
  endtask : rd
  task automatic fpulse(input logic [4:0] m);
    fs <= m;
    @(posedge clk);
    fs <= '0;
    @(posedge clk);
  endtask : fpulse
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done
  // ----
  // stimulus
  // ----
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (lnk.dn_sym_vld) dq.push_back(lnk.dn_sym);
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    nrst = 0; d_lup = 0; f_lup = 0; d_err = '0; fs = '0; lf = 32'h8697;
    awa = '0; ara = '0; wd = '0; wst = 4'hf; awv = 0; wv = 0; arv = 0;
    brdy = 1; rrdy = 1; n_dp = 0; n_fp = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    wr(OFF_PKT_TX, lf);
    check("wr resp", bres, RESP_OKAY);
    fpulse(5'b01000);
    rd(OFF_ERR_STAT); check("port_ok down", rd_v[ES_PORT_OK], 0);
    check("rd resp", rres, RESP_OKAY);
    rd(8'h20); check("unmapped resp", rres, RESP_SLVERR);
    wr(8'h20, lf); check("unmapped wr", bres, RESP_SLVERR);
    d_lup <= 1'b1;
    f_lup <= 1'b1;
    repeat (6) @(posedge clk);
    rd(OFF_ERR_STAT); check("port_ok up", rd_v[ES_PORT_OK], 1);
    $display("test link done");
    for (int o = 0; o < 2; o++) begin
      d_err <= 2'b11;
      fs <= 5'b00011;
      @(posedge clk);
      d_err <= 2'b00;
      fs <= '0;
      repeat (4) @(posedge clk);
      rd(OFF_ERR_DET); check("err det", rd_v, 32'h3);
      rd(OFF_ERR_STAT); check("err stat", rd_v, 32'h17);
      wr(OFF_ERR_DET, 32'h3);
      wr(OFF_ERR_STAT, 32'h10);
      rd(OFF_ERR_DET); check("det clr", rd_v, 32'h0);
      rd(OFF_ERR_STAT); check("stat clr", rd_v, 32'h7);
      check("far stops", {f_is, f_os}, 2'b11);
      dq.delete();
      // only one end starts it; the other must follow on its own
      if (o == 0) wr(OFF_CS_TX, CS_RECOVERY);
      else fpulse(5'b10000);
      repeat (12) @(posedge clk);
      if (o == 0) check("rec sym", {dq[0].st0, dq[0].st1}, 6'o24);
      rd(OFF_ERR_STAT); check("dev resumed", rd_v, 32'h9);
      check("far resumed", {f_ok, f_is, f_os}, 3'b100);
      rd(OFF_LM_RESP); check("lm valid", rd_v[LM_VALID], 1);
      check("lm ack", rd_v[LM_ACK_LSB +: 5], 0);
      check("lm stat", rd_v[4:0], (o == 0) ? 5'h5 : 5'h1);
      rd(OFF_ACK_STAT); check("ids kept", rd_v, 32'h0);
    end
    $display("test recovery done");
    lf = lfsr(lf);
    k = int'(lf[2:0]) + 2;
    for (int i = 0; i < k; i++) begin
      lf = lfsr(lf);
      if (lf[0]) begin
        wr(OFF_PKT_TX, lf);
        n_dp++;
      end else begin
        fpulse(5'b01000);
        n_fp++;
      end
      repeat (8) @(posedge clk);
    end
    rd(OFF_ACK_STAT);
    check("flow ids", rd_v, ackw(5'(n_fp), 5'(n_dp)));
    check("far inb", f_inb, 5'(n_dp));
    // low byte only: outbound cleared, the other ids kept
    wst <= 4'h1;
    wr(OFF_ACK_STAT, 32'h0);
    wst <= 4'hf;
    rd(OFF_ACK_STAT);
    check("strb keep", rd_v, ackw(5'(n_fp), 5'(n_dp)) & ~32'hff);
    $display("test packets done");
    // inbound at the top id so that the realign must wrap
    r1 = lf[9:5];
    wr(OFF_ACK_STAT, ackw(5'h1f, r1));
    wr(OFF_CS_TX, CS_RECOVERY);
    repeat (12) @(posedge clk);
    rd(OFF_ACK_STAT); check("ids kept", rd_v, ackw(5'h1f, r1));
    rd(OFF_LM_RESP); check("lm partner", rd_v[9:5], 5'(n_dp));
    check("far resp", {f_rv, f_ra}, 6'h3f);
    wr(OFF_ACK_STAT, ackw(5'h1f, 5'(n_dp)));
    fpulse(5'b00100);
    repeat (4) @(posedge clk);
    check("far outb", {f_outs, f_outb}, 10'h3ff);
    rd(OFF_ACK_STAT);
    check("realign", rd_v, ackw(5'h0, 5'(n_dp)));
    $display("test realign done");
    test_done();
  end
endmodule : lesr_tb_top
